// file: logic/aisu_map.svh
`ifndef AISU_MAP_SVH
`define AISU_MAP_SVH

// instruction word fields
`define AISU_IW_W          14
`define AISU_FADDR_LSB     0
`define AISU_FADDR_W       7
`define AISU_DEST_POS      7
`define AISU_BSEL_LSB      7
`define AISU_PSEL_POS      6
`define AISU_PLIT_W        6

// opcode patterns, top six bits unless noted
`define AISU_OPC_ADD_IMM   6'h3e
`define AISU_OPC_AND_IMM   6'h39
`define AISU_OPC_ADD_REG   6'h07
`define AISU_OPC_AND_REG   6'h05
`define AISU_OPC_ADDC_REG  6'h3d
`define AISU_OPC_ASR       6'h37
`define AISU_OPC_RET_LIT   6'h34
`define AISU_OPC_PTR_ADD   7'h62
`define AISU_OPC_BCLR      4'h4
`define AISU_OPC_BRANCH    5'h19
`define AISU_OPC_CALL      3'h4
`define AISU_OPC_GOTO      3'h5
`define AISU_OPC_RET_GRP   12'h002

// register port map
`define AISU_ADDR_W        8
`define AISU_A_ACC         8'h80
`define AISU_A_FLAGS       8'h81
`define AISU_A_PTR0_LO     8'h82
`define AISU_A_PTR0_HI     8'h83
`define AISU_A_PTR1_LO     8'h84
`define AISU_A_PTR1_HI     8'h85
`define AISU_A_CORE        8'h86

// flag bit positions in the flag register
`define AISU_FLAG_C        0
`define AISU_FLAG_DC       1
`define AISU_FLAG_Z        2

// reset values
`define AISU_RST_ACC       8'h00
`define AISU_RST_PTR       16'h0000

`endif

// file: logic/aisu_pkg.sv
`default_nettype none

package aisu_pkg;

  typedef struct packed {
    logic z;
    logic dc;
    logic c;
  } aisu_flags_t;

  typedef enum logic [9:0] {
    OP_NONE     = 10'b00_0000_0001,
    OP_PTR_ADD  = 10'b00_0000_0010,
    OP_ADD_IMM  = 10'b00_0000_0100,
    OP_AND_IMM  = 10'b00_0000_1000,
    OP_ADD_REG  = 10'b00_0001_0000,
    OP_AND_REG  = 10'b00_0010_0000,
    OP_ADDC_REG = 10'b00_0100_0000,
    OP_ASR      = 10'b00_1000_0000,
    OP_BCLR     = 10'b01_0000_0000,
    OP_CTRL     = 10'b10_0000_0000
  } aisu_op_t;

  typedef enum logic [1:0] {
    ST_RUN   = 2'b01,
    ST_FLUSH = 2'b10
  } aisu_state_t;

endpackage : aisu_pkg

`default_nettype wire

// file: logic/aisu_regfile.sv
`timescale 1ns/100ps
`default_nettype none

module aisu_regfile #(
  parameter int DEPTH = 128,
  parameter int AW    = 7
) (
  input  wire logic          clk,
  // write port
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [7:0]    wdata,
  // execution read
  input  wire logic [AW-1:0] xaddr,
  output logic      [7:0]    xdata,
  // software read
  input  wire logic [AW-1:0] baddr,
  output logic      [7:0]    bdata
);

  // contents are undefined after reset, as in a real data memory
  logic [7:0] mem [DEPTH];

  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  assign xdata = mem[xaddr];
  assign bdata = mem[baddr];

endmodule : aisu_regfile

`default_nettype wire

// file: logic/aisu_pointer.sv
`timescale 1ns/100ps
`default_nettype none

`include "aisu_map.svh"

module aisu_pointer #(
  parameter int LW = `AISU_PLIT_W
) (
  input  wire logic          clk,
  input  wire logic          rst_n,
  // literal add from execution
  input  wire logic          add_en,
  input  wire logic [LW-1:0] lit,
  // software byte writes
  input  wire logic          wr_lo,
  input  wire logic          wr_hi,
  input  wire logic [7:0]    wdata,
  // current value
  output logic      [15:0]   value
);

  logic [15:0] ext;

  // sign extension of the short literal
  assign ext = {{(16 - LW){lit[LW-1]}}, lit};

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      value <= `AISU_RST_PTR;
    end else if (add_en) begin
      // 16-bit sum drops the carry, so the pointer simply wraps
      value <= value + ext;
    end else if (wr_lo) begin
      value[7:0] <= wdata;
    end else if (wr_hi) begin
      value[15:8] <= wdata;
    end
  end

endmodule : aisu_pointer

`default_nettype wire

// file: logic/aisu_core.sv
// Implementation choices: the register offsets and the strobed register port.
`timescale 1ns/100ps
`default_nettype none

`include "aisu_map.svh"

module aisu_core #(
  parameter int DEPTH = 128
) (
  // clock and reset
  input  wire logic                        CLOCK,
  input  wire logic                        RST_N,
  // instruction issue
  input  wire logic [`AISU_IW_W-1:0]       INSTR_WORD,
  input  wire logic                        INSTR_VALID,
  output logic                             BUSY,
  output logic                             RETIRED,
  // register port
  input  wire logic [`AISU_ADDR_W-1:0]     BUS_ADDR,
  input  wire logic [7:0]                  BUS_WDATA,
  input  wire logic                        BUS_WR,
  input  wire logic                        BUS_RD,
  output logic      [7:0]                  BUS_RDATA,
  // architectural state
  output logic      [7:0]                  ACC,
  output aisu_pkg::aisu_flags_t            FLAGS
);

  import aisu_pkg::*;

  aisu_state_t state;
  aisu_state_t next_state;
  aisu_op_t    op;
  logic        take;

  logic [6:0]  faddr;
  logic        dest_file;
  logic [2:0]  bsel;
  logic [7:0]  lit8;
  logic [7:0]  fval;
  logic [7:0]  bus_fval;

  logic [7:0]  opnd_b;
  logic        cin;
  logic [8:0]  sum9;
  logic [4:0]  sum5;

  logic [7:0]  result;
  logic        to_file;
  logic        to_acc;
  logic        upd_c;
  logic        upd_dc;
  logic        upd_z;
  logic        new_c;

  logic        x_we;
  logic [7:0]  x_wdata;
  logic        rf_we;
  logic [6:0]  rf_waddr;
  logic [7:0]  rf_wdata;

  logic        bus_file;
  logic [1:0]  ptr_add;
  logic [1:0]  ptr_wr_lo;
  logic [1:0]  ptr_wr_hi;
  logic [15:0] ptr_val [2];

  logic [7:0]  next_rdata;

  // instruction fields
  assign faddr     = INSTR_WORD[`AISU_FADDR_LSB +: `AISU_FADDR_W];
  assign dest_file = INSTR_WORD[`AISU_DEST_POS];
  assign bsel      = INSTR_WORD[`AISU_BSEL_LSB +: 3];
  assign lit8      = INSTR_WORD[7:0];

  // a word offered during the idle second cycle is not taken
  assign take = INSTR_VALID && (state == ST_RUN);

  always_comb begin
    op = OP_NONE;
    if (INSTR_WORD[13:7] == `AISU_OPC_PTR_ADD) begin
      op = OP_PTR_ADD;
    end else if (INSTR_WORD[13:8] == `AISU_OPC_ADD_IMM) begin
      op = OP_ADD_IMM;
    end else if (INSTR_WORD[13:8] == `AISU_OPC_AND_IMM) begin
      op = OP_AND_IMM;
    end else if (INSTR_WORD[13:8] == `AISU_OPC_ADD_REG) begin
      op = OP_ADD_REG;
    end else if (INSTR_WORD[13:8] == `AISU_OPC_AND_REG) begin
      op = OP_AND_REG;
    end else if (INSTR_WORD[13:8] == `AISU_OPC_ADDC_REG) begin
      op = OP_ADDC_REG;
    end else if (INSTR_WORD[13:8] == `AISU_OPC_ASR) begin
      op = OP_ASR;
    end else if (INSTR_WORD[13:10] == `AISU_OPC_BCLR) begin
      op = OP_BCLR;
    end else if (INSTR_WORD[13:9] == `AISU_OPC_BRANCH ||
                 INSTR_WORD[13:11] == `AISU_OPC_CALL ||
                 INSTR_WORD[13:11] == `AISU_OPC_GOTO ||
                 INSTR_WORD[13:8] == `AISU_OPC_RET_LIT ||
                 INSTR_WORD[13:2] == `AISU_OPC_RET_GRP) begin
      op = OP_CTRL;
    end
  end

  // shared adder: one 9-bit sum and a 5-bit low nibble sum
  always_comb begin
    opnd_b = fval;
    cin    = 1'b0;
    if (op == OP_ADD_IMM) begin
      opnd_b = lit8;
    end
    if (op == OP_ADDC_REG) begin
      cin = FLAGS.c;
    end
  end

  assign sum9 = {1'b0, ACC} + {1'b0, opnd_b} + {8'h00, cin};
  assign sum5 = {1'b0, ACC[3:0]} + {1'b0, opnd_b[3:0]} + {4'h0, cin};

  // result, destination and which flags move
  always_comb begin
    result  = 8'h00;
    to_file = 1'b0;
    to_acc  = 1'b0;
    upd_c   = 1'b0;
    upd_dc  = 1'b0;
    upd_z   = 1'b0;
    new_c   = sum9[8];
    unique case (op)
      OP_ADD_IMM: begin
        result = sum9[7:0];
        to_acc = 1'b1;
        upd_c  = 1'b1;
        upd_dc = 1'b1;
        upd_z  = 1'b1;
      end
      OP_AND_IMM: begin
        result = ACC & lit8;
        to_acc = 1'b1;
        upd_z  = 1'b1;
      end
      OP_ADD_REG, OP_ADDC_REG: begin
        result  = sum9[7:0];
        to_file = dest_file;
        to_acc  = !dest_file;
        upd_c   = 1'b1;
        upd_dc  = 1'b1;
        upd_z   = 1'b1;
      end
      OP_AND_REG: begin
        result  = ACC & fval;
        to_file = dest_file;
        to_acc  = !dest_file;
        upd_z   = 1'b1;
      end
      OP_ASR: begin
        result  = {fval[7], fval[7:1]};
        new_c   = fval[0];
        to_file = dest_file;
        to_acc  = !dest_file;
        upd_c   = 1'b1;
        upd_z   = 1'b1;
      end
      OP_BCLR: begin
        // only the selected bit drops; flags stay as they are
        result  = fval & ~(8'h01 << bsel);
        to_file = 1'b1;
      end
      OP_PTR_ADD, OP_CTRL, OP_NONE: begin
        result = 8'h00;
      end
    endcase
  end

  // execution write to the file
  assign x_we    = take && to_file;
  assign x_wdata = result;

  // execution owns the write port; a software write in the same
  // cycle is dropped rather than stalling the instruction stream
  assign bus_file = (BUS_ADDR[7] == 1'b0);
  assign rf_we    = x_we || (BUS_WR && bus_file);
  assign rf_waddr = x_we ? faddr : BUS_ADDR[6:0];
  assign rf_wdata = x_we ? x_wdata : BUS_WDATA;

  aisu_regfile #(
    .DEPTH (DEPTH),
    .AW    (7)
  ) u_file (
    .clk   (CLOCK),
    .we    (rf_we),
    .waddr (rf_waddr),
    .wdata (rf_wdata),
    .xaddr (faddr),
    .xdata (fval),
    .baddr (BUS_ADDR[6:0]),
    .bdata (bus_fval)
  );

  // pointer pair: add from execution, byte writes from software
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_ptr
      assign ptr_add[gi] = take && (op == OP_PTR_ADD) &&
                           (INSTR_WORD[`AISU_PSEL_POS] == gi[0]);
      assign ptr_wr_lo[gi] = BUS_WR && (BUS_ADDR == (`AISU_A_PTR0_LO + 8'(2 * gi)));
      assign ptr_wr_hi[gi] = BUS_WR && (BUS_ADDR == (`AISU_A_PTR0_HI + 8'(2 * gi)));

      aisu_pointer #(
        .LW (`AISU_PLIT_W)
      ) u_ptr (
        .clk    (CLOCK),
        .rst_n  (RST_N),
        .add_en (ptr_add[gi]),
        .lit    (INSTR_WORD[`AISU_PLIT_W-1:0]),
        .wr_lo  (ptr_wr_lo[gi]),
        .wr_hi  (ptr_wr_hi[gi]),
        .wdata  (BUS_WDATA),
        .value  (ptr_val[gi])
      );
    end
  endgenerate

  // accumulator
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      ACC <= `AISU_RST_ACC;
    end else if (take && to_acc) begin
      ACC <= result;
    end else if (BUS_WR && BUS_ADDR == `AISU_A_ACC) begin
      ACC <= BUS_WDATA;
    end
  end

  // flags: untouched by pointer add and bit clear
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      FLAGS <= '0;
    end else if (take && (upd_c || upd_dc || upd_z)) begin
      if (upd_c) begin
        FLAGS.c <= new_c;
      end
      if (upd_dc) begin
        FLAGS.dc <= sum5[4];
      end
      if (upd_z) begin
        FLAGS.z <= (result == 8'h00);
      end
    end else if (BUS_WR && BUS_ADDR == `AISU_A_FLAGS) begin
      FLAGS.c  <= BUS_WDATA[`AISU_FLAG_C];
      FLAGS.dc <= BUS_WDATA[`AISU_FLAG_DC];
      FLAGS.z  <= BUS_WDATA[`AISU_FLAG_Z];
    end
  end

  // second cycle of a control transfer is an idle slot
  always_comb begin
    next_state = state;
    unique case (state)
      ST_RUN: begin
        if (take && op == OP_CTRL) begin
          next_state = ST_FLUSH;
        end
      end
      ST_FLUSH: begin
        next_state = ST_RUN;
      end
      default: begin
        next_state = ST_RUN;
      end
    endcase
  end

  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      state <= ST_RUN;
      BUSY  <= 1'b0;
    end else begin
      state <= next_state;
      BUSY  <= (next_state == ST_FLUSH);
    end
  end

  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      RETIRED <= 1'b0;
    end else begin
      RETIRED <= take;
    end
  end

  // software read mux, registered one cycle later
  always_comb begin
    next_rdata = 8'h00;
    if (bus_file) begin
      next_rdata = bus_fval;
    end else begin
      unique case (BUS_ADDR)
        `AISU_A_ACC:     next_rdata = ACC;
        `AISU_A_FLAGS:   next_rdata = {5'h00, FLAGS.z, FLAGS.dc, FLAGS.c};
        `AISU_A_PTR0_LO: next_rdata = ptr_val[0][7:0];
        `AISU_A_PTR0_HI: next_rdata = ptr_val[0][15:8];
        `AISU_A_PTR1_LO: next_rdata = ptr_val[1][7:0];
        `AISU_A_PTR1_HI: next_rdata = ptr_val[1][15:8];
        `AISU_A_CORE:    next_rdata = {7'h00, BUSY};
        default:         next_rdata = 8'h00;
      endcase
    end
  end

  // data stand only in the cycle after the read strobe
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      BUS_RDATA <= 8'h00;
    end else if (BUS_RD) begin
      BUS_RDATA <= next_rdata;
    end else begin
      BUS_RDATA <= 8'h00;
    end
  end

endmodule : aisu_core

`default_nettype wire

// file: testbench/aisu_core_monitor.sv
`timescale 1ns/100ps
`default_nettype none

module aisu_core_monitor #(
  parameter int DEPTH = 128
) (
  // clock and reset
  input wire logic                  CLOCK,
  input wire logic                  RST_N,
  // instruction issue
  input wire logic [13:0]           INSTR_WORD,
  input wire logic                  INSTR_VALID,
  input wire logic                  BUSY,
  input wire logic                  RETIRED,
  // register port
  input wire logic [7:0]            BUS_ADDR,
  input wire logic [7:0]            BUS_WDATA,
  input wire logic                  BUS_WR,
  input wire logic                  BUS_RD,
  input wire logic [7:0]            BUS_RDATA,
  // architectural state
  input wire logic [7:0]            ACC,
  input wire aisu_pkg::aisu_flags_t FLAGS
);
  import aisu_pkg::*;

  default clocking mon_cb @(posedge CLOCK);
  endclocking
  default disable iff (!RST_N);

  logic take;
  assign take = INSTR_VALID && !BUSY;

  AST_RETIRE: assert property (take |=> RETIRED)
    else $error("taken word did not retire");
  AST_GOTO_IDLE: assert property (take && INSTR_WORD[13:11] == 3'h5 |=> BUSY ##1 !BUSY)
    else $error("goto not followed by exactly one idle cycle");
  AST_BUSY_DROP: assert property (BUSY |=> !RETIRED)
    else $error("word offered while busy was retired");
  AST_ADD_IMM: assert property (take && INSTR_WORD[13:8] == 6'h3e |=>
    {FLAGS.c, ACC} == 9'($past(ACC)) + 9'($past(INSTR_WORD[7:0])) && FLAGS.z == (ACC == 8'h00))
    else $error("add immediate sum or carry wrong");
  AST_DC_IMM: assert property (take && INSTR_WORD[13:8] == 6'h3e |=>
    FLAGS.dc == (5'($past(ACC[3:0])) + 5'($past(INSTR_WORD[3:0])) > 5'h0f))
    else $error("nibble carry wrong");
  AST_AND_IMM: assert property (take && INSTR_WORD[13:8] == 6'h39 |=>
    ACC == ($past(ACC) & $past(INSTR_WORD[7:0])) && FLAGS.c == $past(FLAGS.c)
    && FLAGS.dc == $past(FLAGS.dc))
    else $error("and immediate wrong");
  AST_PTR_KEEP: assert property (take && INSTR_WORD[13:7] == 7'h62 && !BUS_WR |=>
    $stable(FLAGS) && $stable(ACC))
    else $error("pointer add touched flags or accumulator");
  AST_BCLR_KEEP: assert property (take && INSTR_WORD[13:10] == 4'h4 && !BUS_WR |=>
    $stable(FLAGS) && $stable(ACC))
    else $error("bit clear touched flags or accumulator");
  AST_RD_IDLE: assert property (!BUS_RD |=> BUS_RDATA == 8'h00)
    else $error("read data outside read answer");

  COV_GOTO: cover property (take && INSTR_WORD[13:11] == 3'h5 ##1 BUSY && INSTR_VALID);
  COV_ADD: cover property (take && INSTR_WORD[13:8] == 6'h3e);
  COV_READ: cover property (BUS_RD);
endmodule : aisu_core_monitor

`default_nettype wire

// file: testbench/alu_instruction_subset_test.sv
`timescale 1ns/100ps
`default_nettype none

module alu_instruction_subset_test;
  import aisu_pkg::*;

  logic        clock, rst_n, valid, wr, rd, busy, retired;
  logic [13:0] word;
  logic [7:0]  addr, wdata, rdata, acc, expv;
  aisu_flags_t flags;
  int          mismatches, checks;
  // one word from each control group besides goto
  logic [13:0] ctrl_words [4] = '{14'h2000, 14'h3200, 14'h3400, 14'h0008};

  aisu_core dut_u (.CLOCK(clock), .RST_N(rst_n), .INSTR_WORD(word), .INSTR_VALID(valid),
    .BUSY(busy), .RETIRED(retired), .BUS_ADDR(addr), .BUS_WDATA(wdata), .BUS_WR(wr),
    .BUS_RD(rd), .BUS_RDATA(rdata), .ACC(acc), .FLAGS(flags));

  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    wr    <= 1'b1;
    addr  <= a;
    wdata <= d;
    @(posedge clock);
    wr <= 1'b0;
  endtask : wr_reg

  // data stand one cycle only, so sample just after the answering edge
  task automatic rd_chk(input string what, input logic [7:0] a, input logic [7:0] exp);
    @(posedge clock);
    rd   <= 1'b1;
    addr <= a;
    @(posedge clock);
    rd <= 1'b0;
    #1 chk(what, exp, rdata);
  endtask : rd_chk

  task automatic setup(input logic [7:0] a, input logic [7:0] f);
    wr_reg(8'h80, a);
    wr_reg(8'h81, f);
  endtask : setup

  task automatic issue(input logic [13:0] w);
    @(posedge clock);
    valid <= 1'b1;
    word  <= w;
    @(posedge clock);
    valid <= 1'b0;
    #1;
  endtask : issue

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : give_verdict

  // hang guard
  initial begin
    repeat (4000) @(posedge clock);
    mismatches++;
    give_verdict();
  end

  initial begin
    rst_n = 1'b0;
    valid = 1'b0;
    word = 14'h0000;
    wr = 1'b0;
    rd = 1'b0;
    addr = 8'h00;
    wdata = 8'h00;
    mismatches = 0;
    checks = 0;
    repeat (12) @(posedge clock);
    rst_n <= 1'b1;
    #1 chk("acc", 8'h00, acc);
    chk("flags", 8'h00, {5'h0, flags});
    rd_chk("ptr0 hi", 8'h83, 8'h00);
    rd_chk("unmapped", 8'h90, 8'h00);
    rd_chk("core", 8'h86, 8'h00);
    setup(8'hfb, 8'h00);
    issue(14'h3e05);
    chk("acc", 8'h00, acc);
    chk("flags", 8'h07, {5'h0, flags});
    setup(8'h0f, 8'h00);
    issue(14'h3e01);
    chk("acc", 8'h10, acc);
    chk("flags", 8'h02, {5'h0, flags});
    setup(8'hf0, 8'h03);
    issue(14'h390f);
    chk("acc", 8'h00, acc);
    chk("flags", 8'h07, {5'h0, flags});
    wr_reg(8'h10, 8'h80);
    setup(8'h80, 8'h00);
    issue(14'h0710);
    chk("acc", 8'h00, acc);
    chk("flags", 8'h05, {5'h0, flags});
    wr_reg(8'h10, 8'h0f);
    setup(8'h01, 8'h00);
    issue(14'h0790);
    rd_chk("file", 8'h10, 8'h10);
    chk("acc", 8'h01, acc);
    chk("flags", 8'h02, {5'h0, flags});
    wr_reg(8'h20, 8'h3c);
    setup(8'hc3, 8'h00);
    issue(14'h05a0);
    rd_chk("file", 8'h20, 8'h00);
    chk("flags", 8'h04, {5'h0, flags});
    wr_reg(8'h11, 8'h00);
    setup(8'h0f, 8'h01);
    issue(14'h3d11);
    chk("acc", 8'h10, acc);
    chk("flags", 8'h02, {5'h0, flags});
    wr_reg(8'h12, 8'h81);
    setup(8'h00, 8'h02);
    issue(14'h3792);
    rd_chk("file", 8'h12, 8'hc0);
    chk("flags", 8'h03, {5'h0, flags});
    wr_reg(8'h13, 8'hff);
    setup(8'h00, 8'h05);
    expv = 8'hff;
    for (int b = 0; b < 8; b++) begin
      issue({4'h4, 3'(b), 7'h13});
      expv[b] = 1'b0;
      rd_chk("file", 8'h13, expv);
    end
    chk("flags", 8'h05, {5'h0, flags});
    wr_reg(8'h82, 8'h01);
    wr_reg(8'h83, 8'h00);
    issue({7'h62, 1'b0, 6'h20});
    rd_chk("ptr0 lo", 8'h82, 8'he1);
    rd_chk("ptr0 hi", 8'h83, 8'hff);
    wr_reg(8'h84, 8'hff);
    wr_reg(8'h85, 8'hff);
    issue({7'h62, 1'b1, 6'h01});
    rd_chk("ptr1 lo", 8'h84, 8'h00);
    rd_chk("ptr1 hi", 8'h85, 8'h00);
    chk("flags", 8'h05, {5'h0, flags});
    setup(8'h00, 8'h00);
    @(posedge clock);
    valid <= 1'b1;
    word  <= 14'h2800;
    @(posedge clock);
    word <= 14'h3e01;
    #1 chk("busy", 8'h01, {7'h0, busy});
    chk("retired", 8'h01, {7'h0, retired});
    @(posedge clock);
    #1 chk("retired", 8'h00, {7'h0, retired});
    @(posedge clock);
    valid <= 1'b0;
    #1 chk("acc", 8'h01, acc);
    chk("retired", 8'h01, {7'h0, retired});
    for (int i = 0; i < 4; i++) begin
      issue(ctrl_words[i]);
      chk("busy", 8'h01, {7'h0, busy});
    end
    issue(14'h0000);
    chk("busy", 8'h00, {7'h0, busy});
    chk("acc", 8'h01, acc);
    give_verdict();
  end
endmodule : alu_instruction_subset_test

bind aisu_core aisu_core_monitor #(.DEPTH(DEPTH)) mon_u (.CLOCK, .RST_N, .INSTR_WORD,
  .INSTR_VALID, .BUSY, .RETIRED, .BUS_ADDR, .BUS_WDATA, .BUS_WR, .BUS_RD, .BUS_RDATA,
  .ACC, .FLAGS);

`default_nettype wire
